// ### core/alert_pkg.sv
// Constants and carrier types for the limit, flag and alert logic.
// Assumes a single 200 MHz clock and results delivered already converted.
package alert_pkg;

    // ********************************************************************
    // Register addresses and widths
    // ********************************************************************
    localparam int          ADDR_W              = 6;
    localparam int          DATA_W              = 16;
    localparam logic [5:0]  DIAG_ADDR           = 6'h0B;
    localparam logic [5:0]  SHUNT_OVER_ADDR     = 6'h0C;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [15:0] DIAG_RESET          = 16'h0001;
    localparam logic [15:0] SHUNT_OVER_RESET    = 16'h7FFF;

    // ********************************************************************
    // Diagnostic register field positions
    // ********************************************************************
    localparam int          LATCH_BIT           = 15;
    localparam int          READY_ALERT_BIT     = 14;
    localparam int          AVG_ALERT_BIT       = 13;
    localparam int          POLARITY_BIT        = 12;
    localparam int          OVERFLOW_BIT        = 9;
    localparam int          LIMIT_LSB           = 2;
    localparam int          LIMIT_MSB           = 7;
    localparam int          READY_BIT           = 1;
    localparam int          CHECKSUM_BIT        = 0;
    localparam int          NUM_LIMITS          = 6;

    // ********************************************************************
    // Limit vector order, bit 0 lowest register bit
    // ********************************************************************
    localparam int          LIM_POWER_OVER      = 0;
    localparam int          LIM_BUS_UNDER       = 1;
    localparam int          LIM_BUS_OVER        = 2;
    localparam int          LIM_SHUNT_UNDER     = 3;
    localparam int          LIM_SHUNT_OVER      = 4;
    localparam int          LIM_TEMP_OVER       = 5;

    // ********************************************************************
    // Power limit scaling: limit LSB is 256 power LSBs
    // ********************************************************************
    localparam int          POWER_LIMIT_SHIFT   = 8;

    typedef struct packed {
        logic [5:0]  addr;
        logic        wr;
        logic        rd;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic signed [11:0] temp;
        logic signed [15:0] shunt;
        logic        [15:0] bus;
        logic        [23:0] power;
    } results_t;

    typedef struct packed {
        logic signed [11:0] temp_limit;
        logic signed [15:0] shunt_under;
        logic        [14:0] bus_over;
        logic        [14:0] bus_under;
        logic        [15:0] power_limit;
    } limits_t;

endpackage : alert_pkg

// ### core/limit_alert_flag_logic.sv
// Limit comparison, diagnostic flags and alert pin drive of a power monitor.
// Assumes a register port from the serial interface with one-cycle strobes,
// and result strobes from the converter and averager in the same clock domain.
//
// Function
// - Averaged-alert bit picks averaged or raw results
// - Polarity bit selects active-low or active-high alert
// - Reserved diagnostic bits read zero
// - Arithmetic overflow sets overflow flag
// - Overflow flag cleared only by new conversion
// - Temperature above limit sets its flag
// - Shunt above over threshold sets its flag
// - Shunt below under threshold sets its flag
// - Bus above over limit sets its flag
// - Bus below under limit sets its flag
// - Power above power limit sets its flag
// - Latch mode holds limit flags until read
// - Completed conversion sets ready flag
// - Latched ready cleared by read or start
// - Checksum status resets one, zero on error
// - Shunt threshold signed 16 bit, range-scaled
// - Shunt threshold at address C, reset 7FFF
// - Signed compare; negative threshold trips at zero
// - Latch bit selects transparent or latched flags
// - Ready-on-alert bit routes ready flag to alert
module limit_alert_flag_logic
    import alert_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Register port
    input  alert_pkg::reg_req_t         reg_req,
    output logic [15:0]                 reg_rdata,
    // Result port
    input  wire logic                   raw_valid,
    input  wire logic                   avg_valid,
    input  alert_pkg::results_t         results,
    input  alert_pkg::limits_t          limits,
    // Conversion events
    input  wire logic                   conv_start,
    input  wire logic                   math_overflow_event,
    input  wire logic                   checksum_error,
    // Alert pin
    output logic                        alert_out,
    output logic                        alert_oe,
    output logic                        alert_active
);

    // ********************************************************************
    // Declarations
    // ********************************************************************
    logic                       latch_q;
    logic                       ready_alert_q;
    logic                       avg_alert_q;
    logic                       polarity_q;

    logic signed [15:0]         shunt_over_q;
    logic [NUM_LIMITS-1:0]      limit_flag_q;
    logic [NUM_LIMITS-1:0]      limit_flag_d;
    logic                       overflow_q;
    logic                       ready_q;
    logic                       checksum_ok_q;
    logic [15:0]                rdata_q;
    logic                       alert_q;
    logic                       alert_oe_q;
    logic                       alert_out_q;

    logic [NUM_LIMITS-1:0]      violation;
    logic                       sample;
    logic                       diag_read;
    logic                       diag_write;
    logic                       shunt_write;
    logic                       flag_clear;
    logic                       alert_d;
    logic [15:0]                diag_value;
    logic [15:0]                rdata_d;
    logic                       ready_d;
    logic                       ready_clear;
    logic [1:0]                 alert_src;
    logic                       diag_hit;
    logic                       shunt_hit;
    logic                       raw_sample;
    logic                       avg_sample;
    logic                       overflow_set;
    logic                       overflow_clear;

    // ********************************************************************
    // Register decode
    // ********************************************************************
    assign diag_hit    = (reg_req.addr == DIAG_ADDR);
    assign shunt_hit   = (reg_req.addr == SHUNT_OVER_ADDR);
    assign diag_read   = reg_req.rd && diag_hit;
    assign diag_write  = reg_req.wr && diag_hit;
    assign shunt_write = reg_req.wr && shunt_hit;
    assign flag_clear  = diag_read && latch_q;

    // ********************************************************************
    // Configuration bits
    // ********************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            latch_q <= DIAG_RESET[LATCH_BIT];
        end else if (diag_write) begin
            latch_q <= reg_req.wdata[LATCH_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_alert_q <= DIAG_RESET[READY_ALERT_BIT];
        end else if (diag_write) begin
            ready_alert_q <= reg_req.wdata[READY_ALERT_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            avg_alert_q <= DIAG_RESET[AVG_ALERT_BIT];
        end else if (diag_write) begin
            avg_alert_q <= reg_req.wdata[AVG_ALERT_BIT];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            polarity_q <= DIAG_RESET[POLARITY_BIT];
        end else if (diag_write) begin
            polarity_q <= reg_req.wdata[POLARITY_BIT];
        end
    end

    // ********************************************************************
    // Shunt over-limit threshold
    // ********************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shunt_over_q <= SHUNT_OVER_RESET;
        end else if (shunt_write) begin
            shunt_over_q <= reg_req.wdata;
        end
    end

    // ********************************************************************
    // Limit comparison
    // ********************************************************************
    assign raw_sample = raw_valid && !avg_alert_q;
    assign avg_sample = avg_valid && avg_alert_q;
    assign sample     = raw_sample || avg_sample;

    limit_compare i_limit_compare (
        .results    (results),
        .limits     (limits),
        .shunt_over (shunt_over_q),
        .violation  (violation)
    );

    // ********************************************************************
    // Limit flags
    // ********************************************************************
    generate
        for (genvar i = 0; i < NUM_LIMITS; i++) begin : g_limit
            always_comb begin
                limit_flag_d[i] = flag_clear ? 1'b0 : limit_flag_q[i];
                if (sample) begin
                    if (latch_q) begin
                        limit_flag_d[i] = limit_flag_d[i] | violation[i];
                    end else begin
                        limit_flag_d[i] = violation[i];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            limit_flag_q <= DIAG_RESET[LIMIT_MSB:LIMIT_LSB];
        end else begin
            limit_flag_q <= limit_flag_d;
        end
    end

    // ********************************************************************
    // Arithmetic overflow flag
    // ********************************************************************
    assign overflow_set   = math_overflow_event;
    assign overflow_clear = conv_start;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            overflow_q <= DIAG_RESET[OVERFLOW_BIT];
        end else if (overflow_set) begin
            overflow_q <= 1'b1;
        end else if (overflow_clear) begin
            overflow_q <= 1'b0;
        end
    end

    // ********************************************************************
    // Conversion ready flag
    // ********************************************************************
    assign ready_clear = conv_start || flag_clear;

    always_comb begin
        ready_d = ready_q;
        if (avg_valid) begin
            ready_d = 1'b1;
        end else if (ready_clear) begin
            ready_d = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ready_q <= DIAG_RESET[READY_BIT];
        end else begin
            ready_q <= ready_d;
        end
    end

    // ********************************************************************
    // Trim checksum status
    // ********************************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            checksum_ok_q <= DIAG_RESET[CHECKSUM_BIT];
        end else if (checksum_error) begin
            checksum_ok_q <= 1'b0;
        end
    end

    // ********************************************************************
    // Read data
    // ********************************************************************
    always_comb begin
        diag_value                      = 16'h0000;
        diag_value[LATCH_BIT]           = latch_q;
        diag_value[READY_ALERT_BIT]     = ready_alert_q;
        diag_value[AVG_ALERT_BIT]       = avg_alert_q;
        diag_value[POLARITY_BIT]        = polarity_q;
        diag_value[OVERFLOW_BIT]        = overflow_q;
        diag_value[LIMIT_MSB:LIMIT_LSB] = limit_flag_q;
        diag_value[READY_BIT]           = ready_q;
        diag_value[CHECKSUM_BIT]        = checksum_ok_q;
    end

    always_comb begin
        unique case (reg_req.addr)
            DIAG_ADDR:       rdata_d = diag_value;
            SHUNT_OVER_ADDR: rdata_d = shunt_over_q;
            default:         rdata_d = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 16'h0000;
        end else if (reg_req.rd) begin
            rdata_q <= rdata_d;
        end
    end

    // ********************************************************************
    // Alert pin
    // ********************************************************************
    assign alert_src[0] = |limit_flag_d;
    assign alert_src[1] = ready_alert_q && ready_d;
    assign alert_d      = |alert_src;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= alert_d;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alert_oe_q <= 1'b0;
        end else begin
            alert_oe_q <= alert_d ^ polarity_q;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            alert_out_q <= 1'b0;
        end else begin
            alert_out_q <= 1'b0;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign reg_rdata    = rdata_q;
    assign alert_out    = alert_out_q;
    assign alert_oe     = alert_oe_q;
    assign alert_active = alert_q;

endmodule : limit_alert_flag_logic

// ### core/limit_compare.sv
// Combinational comparison of one result set against all limits.
// Assumes results and limits are stable while the sample strobe is high.
module limit_compare
    import alert_pkg::*;
(
    input  alert_pkg::results_t         results,
    input  alert_pkg::limits_t          limits,
    input  wire logic signed [15:0]     shunt_over,
    output logic [alert_pkg::NUM_LIMITS-1:0] violation
);

    // ********************************************************************
    // Comparators
    // ********************************************************************
    logic [15:0] power_scaled;

    assign power_scaled = results.power[23:POWER_LIMIT_SHIFT];

    assign violation[LIM_TEMP_OVER]   = results.temp > limits.temp_limit;
    assign violation[LIM_SHUNT_OVER]  = results.shunt > shunt_over;
    assign violation[LIM_SHUNT_UNDER] = results.shunt < limits.shunt_under;
    assign violation[LIM_BUS_OVER]    = results.bus > {1'b0, limits.bus_over};
    assign violation[LIM_BUS_UNDER]   = results.bus < {1'b0, limits.bus_under};
    assign violation[LIM_POWER_OVER]  = power_scaled > limits.power_limit;

endmodule : limit_compare

// ### testbench/limit_alert_flag_logic_properties.sv
// Port-level checker for the limit, flag and alert block.
// Assumes one clk domain with asynchronous active-high reset.
module limit_alert_flag_checker
    import alert_pkg::*;
(
    input  wire logic           clk,
    input  wire logic           reset,
    input  alert_pkg::reg_req_t reg_req,
    input  wire logic [15:0]    reg_rdata,
    input  wire logic           avg_valid,
    input  wire logic           conv_start,
    input  wire logic           math_overflow_event,
    input  wire logic           checksum_error,
    input  wire logic           alert_out,
    input  wire logic           alert_oe,
    input  wire logic           alert_active
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************************************************
    // Shadow state
    // ********************************************************************
    logic [3:0] cfg_q;
    logic       err_q;
    logic       ovf_q;
    logic       rdy_q;
    wire logic  diag_rd = reg_req.rd && reg_req.addr == DIAG_ADDR;
    wire logic  diag_wr = reg_req.wr && reg_req.addr == DIAG_ADDR;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_q <= 4'h0;
            err_q <= 1'b0;
            ovf_q <= 1'b0;
            rdy_q <= 1'b0;
        end else begin
            if (diag_wr) begin
                cfg_q <= reg_req.wdata[15:12];
            end
            err_q <= err_q | checksum_error;
            ovf_q <= math_overflow_event | (ovf_q & ~conv_start);
            rdy_q <= avg_valid | (rdy_q & ~conv_start & ~(cfg_q[3] & diag_rd));
        end
    end
    // ********************************************************************
    // Properties
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_out_released: assert property (alert_out == 1'b0)
        else $error("alert_out driven high");
    a_oe_sense: assert property (
        $past(cfg_q[0]) == cfg_q[0] |-> alert_oe == (alert_active ^ cfg_q[0]))
        else $error("alert_oe sense wrong");
    a_reserved_zero: assert property (
        diag_rd |=> reg_rdata[11:10] == 2'h0 && reg_rdata[8] == 1'b0)
        else $error("reserved diagnostic bits set");
    a_cfg_readback: assert property (
        diag_rd |=> reg_rdata[15:12] == $past(cfg_q))
        else $error("configuration bits read back wrong");
    a_checksum_error: assert property (
        diag_rd && err_q |=> reg_rdata[0] == 1'b0)
        else $error("checksum status not cleared");
    a_overflow_flag: assert property (
        diag_rd |=> reg_rdata[9] == $past(ovf_q))
        else $error("overflow flag wrong");
    a_ready_flag: assert property (
        diag_rd |=> reg_rdata[1] == $past(rdy_q))
        else $error("ready flag wrong");
    a_ready_alert: assert property (
        cfg_q[2] && avg_valid && !diag_wr |=> alert_active)
        else $error("ready did not raise alert");
    a_latch_hold: assert property (
        cfg_q[3] && alert_active && !diag_rd && !diag_wr && !conv_start |=> alert_active)
        else $error("latched alert dropped without read");
endmodule : limit_alert_flag_checker

// ### testbench/tb_limit_alert_flag_logic.sv
// Self-checking bench for the limit, flag and alert block.
// Assumes alert_pkg, the design and the checker are compiled first.
module tb_limit_alert_flag_logic;
    timeunit 1ns;
    timeprecision 1ps;
    import alert_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    reg_req_t    req = '0;
    logic [15:0] rdata;
    logic        raw_valid = 1'b0;
    logic        avg_valid = 1'b0;
    results_t    res = '0;
    limits_t     lim = {12'h064, 16'hFF9C, 15'h03E8, 15'h0064, 16'h0100};
    logic        conv_start = 1'b0;
    logic        ovf_ev = 1'b0;
    logic        cks_err = 1'b0;
    logic        alert_out;
    logic        alert_oe;
    logic        alert_active;
    logic [15:0] e;
    int          n_mismatch = 0;
    int          checks_done = 0;
    results_t    base = {12'h000, 16'h0000, 16'h01F4, 24'h0};
    results_t    tv [12] = '{
        {12'h065, 16'h0000, 16'h01F4, 24'h0}, {12'h064, 16'h0000, 16'h01F4, 24'h0},
        {12'h000, 16'h00C9, 16'h01F4, 24'h0}, {12'h000, 16'h00C8, 16'h01F4, 24'h0},
        {12'h000, 16'hFF9B, 16'h01F4, 24'h0}, {12'h000, 16'hFF9C, 16'h01F4, 24'h0},
        {12'h000, 16'h0000, 16'h03E9, 24'h0}, {12'h000, 16'h0000, 16'h03E8, 24'h0},
        {12'h000, 16'h0000, 16'h0063, 24'h0}, {12'h000, 16'h0000, 16'h0064, 24'h0},
        {12'h000, 16'h0000, 16'h01F4, 24'h010100}, {12'h000, 16'h0000, 16'h01F4, 24'h0100FF}};
    limit_alert_flag_logic i_limit_alert_flag_logic (
        .clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .raw_valid(raw_valid),
        .avg_valid(avg_valid), .results(res), .limits(lim), .conv_start(conv_start),
        .math_overflow_event(ovf_ev), .checksum_error(cks_err), .alert_out(alert_out),
        .alert_oe(alert_oe), .alert_active(alert_active));
    always #2.5 clk = ~clk;
    // ********************************************************************
    // Access tasks
    // ********************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
        @(negedge clk);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk);
        req.rd = 1'b0;
        check(rdata, exp);
    endtask : rd_chk
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(negedge clk);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk);
        req.wr = 1'b0;
    endtask : wr
    task automatic smp(input logic avg, input results_t r);
        @(negedge clk);
        res = r;
        raw_valid = ~avg;
        avg_valid = avg;
        @(negedge clk);
        raw_valid = 1'b0;
        avg_valid = 1'b0;
    endtask : smp
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    // ********************************************************************
    // Tests
    // ********************************************************************
    initial begin
        repeat (8) @(negedge clk);
        reset = 1'b0;
        rd_chk(DIAG_ADDR, 16'h0001);
        rd_chk(SHUNT_OVER_ADDR, 16'h7FFF);
        rd_chk(6'h3F, 16'h0000);
        wr(SHUNT_OVER_ADDR, 16'h00C8);
        wr(6'h3F, 16'h1234);
        rd_chk(SHUNT_OVER_ADDR, 16'h00C8);
        for (int i = 0; i < 12; i++) begin
            smp(1'b0, tv[i]);
            e = (i % 2) ? 16'h0001 : 16'h0001 | (16'h0080 >> (i / 2));
            check(16'(alert_active), 16'(e != 16'h0001));
            check(16'(alert_oe), 16'(e != 16'h0001));
            rd_chk(DIAG_ADDR, e);
        end
        wr(SHUNT_OVER_ADDR, 16'hFFF0);
        smp(1'b0, base);
        rd_chk(DIAG_ADDR, 16'h0041);
        wr(SHUNT_OVER_ADDR, 16'h00C8);
        smp(1'b0, base);
        wr(DIAG_ADDR, 16'h1000);
        @(negedge clk);
        check(16'(alert_oe), 16'h0001);
        smp(1'b0, tv[0]);
        check(16'(alert_oe), 16'h0000);
        smp(1'b0, base);
        wr(DIAG_ADDR, 16'h8000);
        smp(1'b0, tv[0]);
        smp(1'b0, base);
        check(16'(alert_active), 16'h0001);
        rd_chk(DIAG_ADDR, 16'h8081);
        rd_chk(DIAG_ADDR, 16'h8001);
        check(16'(alert_active), 16'h0000);
        wr(DIAG_ADDR, 16'h2000);
        smp(1'b0, tv[0]);
        rd_chk(DIAG_ADDR, 16'h2001);
        smp(1'b1, tv[0]);
        rd_chk(DIAG_ADDR, 16'h2083);
        pulse(conv_start);
        rd_chk(DIAG_ADDR, 16'h2081);
        wr(DIAG_ADDR, 16'h4000);
        smp(1'b0, base);
        check(16'(alert_active), 16'h0000);
        smp(1'b1, base);
        check(16'(alert_active), 16'h0001);
        wr(DIAG_ADDR, 16'hC000);
        rd_chk(DIAG_ADDR, 16'hC003);
        rd_chk(DIAG_ADDR, 16'hC001);
        pulse(ovf_ev);
        rd_chk(DIAG_ADDR, 16'hC201);
        rd_chk(DIAG_ADDR, 16'hC201);
        pulse(conv_start);
        rd_chk(DIAG_ADDR, 16'hC001);
        pulse(cks_err);
        wr(DIAG_ADDR, 16'hFFFF);
        rd_chk(DIAG_ADDR, 16'hF000);
        report_and_stop();
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_limit_alert_flag_logic
bind limit_alert_flag_logic limit_alert_flag_checker i_limit_alert_flag_checker (
    .clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .avg_valid(avg_valid),
    .conv_start(conv_start), .math_overflow_event(math_overflow_event),
    .checksum_error(checksum_error), .alert_out(alert_out), .alert_oe(alert_oe),
    .alert_active(alert_active));
